// >>> design/sess_seq.sv
/*
  Start-up gate and soft-start sequencer with power-good.
  Assumes comparator and POR flags arrive asynchronously from analog;
  the step period for the ramp-rate resistor is supplied as a count.
*/
// Notes on behaviour
// - PWM outputs tristated while in shutdown
// - Bias supply POR required to leave shutdown
// - Main enable above threshold, with hysteresis
// - External driver enable required for release
// - Driver supplies POR per phase count
// - Soft-start starts at once in every mode
// - Code 11111 blocks start in 5-bit mode
// - Initial delay precedes any ramping
// - First ramp climbs to boot voltage
// - Hold boot level 85 us plus validation
// - Code validation lasts at least 500 ns
// - Valid code starts second ramp to target
// - One DAC step per oscillator tick
// - Grounded rate pin gives 330 kHz steps
// - Power-good rises 440 us after final
// - Power-good low in shutdown and soft-start
`timescale 1ns/1ps
module sess_seq import sess_pkg::*; #(
  parameter int unsigned INIT_CYC  = INIT_DELAY_CYC,
  parameter int unsigned HLD_CYC   = HOLD_CYC,
  parameter int unsigned GD_CYC    = GOOD_CYC,
  parameter int unsigned PHASES    = 3
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             bias_por_ok,
  input  wire logic             enable_above,
  input  wire logic             ext_driver_enable_in,
  input  wire logic             first_driver_supply,
  input  wire logic             second_driver_supply,
  input  wire logic             third_driver_supply,
  input  wire logic             output_in_window,
  input  wire sess_mode_t       mode,
  input  wire logic             ramp_pin_grounded,
  input  wire logic [15:0]      ramp_period_cyc,
  input  wire logic [VID_W-1:0] voltage_id_code,
  input  wire logic             code_valid,
  output logic [DAC_W-1:0]      dac_code,
  output logic                  pwm_out_en,
  output logic                  power_good_out,
  output logic                  soft_start_busy
);
  if (PHASES < 2 || PHASES > 3) begin : g_bad_phases
    $error("PHASES must be 2 or 3");
  end
  if (INIT_CYC < 1 || HLD_CYC < 1 || GD_CYC < 1) begin : g_bad_count
    $error("Delay counts must be at least 1");
  end

  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] s1_reg, s2_reg;
  // Code bits may skew; valid is synced alongside and gates the read
  logic [VID_W-1:0] vid_s1_reg, vid_s2_reg;
  logic [NSYNC-1:0] async_in;
  assign async_in = {output_in_window, code_valid, third_driver_supply,
    second_driver_supply, first_driver_supply, ext_driver_enable_in,
    enable_above, bias_por_ok};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      vid_s1_reg <= '0;
      vid_s2_reg <= '0;
    end else begin
      s1_reg     <= async_in;
      s2_reg     <= s1_reg;
      vid_s1_reg <= voltage_id_code;
      vid_s2_reg <= vid_s1_reg;
    end
  end

  logic bias_ok, en_ok, ext_ok, drv_ok, vld_s, win_s;
  assign bias_ok = s2_reg[0];
  assign en_ok   = s2_reg[1];
  assign ext_ok  = s2_reg[2];
  // Unused phases may be left unpowered in a smaller build
  assign drv_ok  = s2_reg[3] && s2_reg[4] &&
                   (PHASES < 3 || s2_reg[5]);
  assign vld_s   = s2_reg[6];
  assign win_s   = s2_reg[7];

  // Hysteresis lives in the analog comparators; digital just gates
  logic release_ok, no_load;
  assign no_load    = (mode == SESS_MODE_B5) &&
                      (vid_s2_reg[4:0] == NO_LOAD_CODE);
  assign release_ok = bias_ok && en_ok && ext_ok && drv_ok && !no_load;

  sess_step_if st ();
  sess_step_osc u_osc (
    .clk  (clk),
    .nrst (nrst),
    .st   (st)
  );

  sess_state_t          state_reg, state_next;
  logic [31:0]          cnt_reg, cnt_next;
  logic [DAC_W-1:0]     dac_reg, dac_next;
  logic [DAC_W-1:0]     tgt_reg, tgt_next;
  logic                 pg_reg, pg_next;
  logic                 en_reg, en_next;

  function automatic logic [DAC_W-1:0] step_to(
    input logic [DAC_W-1:0] cur,
    input logic [DAC_W-1:0] goal
  );
    if (cur < goal) step_to = cur + 8'h01;
    else if (cur > goal) step_to = cur - 8'h01;
    else step_to = cur;
  endfunction

  assign st.run    = (state_reg == SESS_RAMP1) || (state_reg == SESS_RAMP2);
  assign st.period = ramp_pin_grounded ? 16'(STEP_DEF_CYC)
                                       : ramp_period_cyc;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    dac_next   = dac_reg;
    tgt_next   = tgt_reg;
    pg_next    = 1'b0;
    en_next    = 1'b1;
    case (state_reg)
      SESS_SHUT: begin
        en_next  = 1'b0;
        dac_next = '0;
        cnt_next = '0;
        if (release_ok) begin
          state_next = SESS_INIT;
        end
      end
      SESS_INIT: begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg + 32'h1 >= INIT_CYC) begin
          cnt_next   = '0;
          state_next = SESS_RAMP1;
        end
      end
      SESS_RAMP1: begin
        if (st.tick) begin
          dac_next = step_to(dac_reg, BOOT_CODE);
        end
        if (dac_reg == BOOT_CODE) begin
          state_next = SESS_HOLD;
        end
      end
      SESS_HOLD: begin
        if (cnt_reg < HLD_CYC) begin
          cnt_next = cnt_reg + 32'h1;
        end else if (!vld_s) begin
          cnt_next = HLD_CYC;
        end else if (cnt_reg + 32'h1 >= HLD_CYC + VALID_CYC) begin
          tgt_next   = vid_s2_reg[DAC_W-1:0];
          cnt_next   = '0;
          state_next = SESS_RAMP2;
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      SESS_RAMP2: begin
        if (st.tick) begin
          dac_next = step_to(dac_reg, tgt_reg);
        end
        if (dac_reg == tgt_reg) begin
          cnt_next   = '0;
          state_next = SESS_GOOD_WAIT;
        end
      end
      SESS_GOOD_WAIT: begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg + 32'h1 >= GD_CYC) begin
          state_next = SESS_RUN;
        end
      end
      SESS_RUN: begin
        pg_next = win_s;
      end
      default: state_next = SESS_SHUT;
    endcase
    if (!release_ok) begin
      state_next = SESS_SHUT;
      pg_next    = 1'b0;
      en_next    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SESS_SHUT;
      cnt_reg   <= '0;
      dac_reg   <= '0;
      tgt_reg   <= '0;
      pg_reg    <= 1'b0;
      en_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      dac_reg   <= dac_next;
      tgt_reg   <= tgt_next;
      pg_reg    <= pg_next;
      en_reg    <= en_next;
    end
  end

  logic busy_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) busy_reg <= 1'b0;
    else busy_reg <= (state_next != SESS_SHUT) && (state_next != SESS_RUN);
  end

  assign dac_code        = dac_reg;
  assign pwm_out_en      = en_reg;
  assign power_good_out  = pg_reg;
  assign soft_start_busy = busy_reg;

  sequence s_lost;
    !release_ok;
  endsequence

  a_shut_tristate: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_SHUT |=> !pwm_out_en)
    else $error("pwm enabled in shutdown");
  a_lost_restart: assert property (@(posedge clk) disable iff (!nrst)
    s_lost |=> state_reg == SESS_SHUT && !power_good_out)
    else $error("no return to shutdown");
  a_no_load_hold: assert property (@(posedge clk) disable iff (!nrst)
    no_load |=> state_reg == SESS_SHUT)
    else $error("start with no-load code");
  a_release_start: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_SHUT && release_ok |=> state_reg == SESS_INIT)
    else $error("start not immediate");
  a_init_no_ramp: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_INIT |-> dac_reg == '0)
    else $error("dac moved in initial delay");
  a_ramp_step: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_RAMP1 && !st.tick && release_ok
    |=> $stable(dac_reg))
    else $error("dac step without tick");
  a_hold_boot: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_HOLD |-> dac_reg == BOOT_CODE)
    else $error("hold not at boot level");
  a_pg_low_ss: assert property (@(posedge clk) disable iff (!nrst)
    state_reg != SESS_RUN |=> !power_good_out)
    else $error("power good during soft-start");
  a_ramp2_dir: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_RAMP2 && tgt_reg < dac_reg && release_ok
    |=> dac_reg <= $past(dac_reg))
    else $error("second ramp wrong direction");
  a_boot_reach: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == SESS_RAMP1 && dac_reg == BOOT_CODE && release_ok
    |=> state_reg == SESS_HOLD)
    else $error("no hold after boot");
endmodule

// >>> design/sess_pkg.sv
/*
  Constants for the start-up and soft-start sequencer.
  Assumes a 40 MHz core clock; DAC codes are in 6.25 mV steps.
*/
package sess_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned NS_PER_S        = 1_000_000_000;
  localparam int unsigned US_PER_S        = 1_000_000;
  localparam int unsigned INIT_DELAY_US_X100 = 140;
  localparam int unsigned INIT_DELAY_CYC  =
    (CLK_HZ / US_PER_S) * INIT_DELAY_US_X100 * 10;
  localparam int unsigned HOLD_US         = 85;
  localparam int unsigned HOLD_CYC        = (CLK_HZ / US_PER_S) * HOLD_US;
  localparam int unsigned VALID_NS        = 500;
  localparam int unsigned VALID_CYC       =
    (CLK_HZ / 1_000_000 * VALID_NS + 999) / 1000;
  localparam int unsigned GOOD_US         = 440;
  localparam int unsigned GOOD_CYC        = (CLK_HZ / US_PER_S) * GOOD_US;
  localparam int unsigned STEP_DEF_HZ     = 330_000;
  localparam int unsigned STEP_DEF_CYC    = CLK_HZ / STEP_DEF_HZ;
  localparam int unsigned DAC_W           = 8;
  localparam int unsigned VID_W           = 8;
  localparam logic [DAC_W-1:0] BOOT_CODE  = 8'hb0;
  localparam logic [4:0] NO_LOAD_CODE     = 5'h1f;
  typedef enum logic [1:0] {
    SESS_MODE_A1, SESS_MODE_A2, SESS_MODE_B6, SESS_MODE_B5
  } sess_mode_t;
  typedef enum {
    SESS_SHUT, SESS_INIT, SESS_RAMP1, SESS_HOLD, SESS_RAMP2, SESS_GOOD_WAIT,
    SESS_RUN
  } sess_state_t;
endpackage

// >>> design/sess_step_if.sv
/*
  Step-tick carrier between the sequencer and its step oscillator.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface sess_step_if;
  logic        run;
  logic [15:0] period;
  logic        tick;
  modport ctrl (output run, output period, input tick);
  modport osc  (input run, input period, output tick);
endinterface

// >>> design/sess_step_osc.sv
/*
  Soft-start step oscillator: one-cycle tick every period clocks.
  Assumes the period is stable while run is high.
*/
`timescale 1ns/1ps
module sess_step_osc (
  input  wire logic clk,
  input  wire logic nrst,
  sess_step_if.osc  st
);
  logic [15:0] cnt_reg, cnt_next;
  logic        tick_reg, tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!st.run) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg + 16'h0001 >= st.period) begin
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign st.tick = tick_reg;
endmodule

// >>> bench/sess_vid_model.sv
/*
  Processor side: drives the identification code, with valid low
  for SETTLE+1 clocks after every change. Assumes one shared clock.
*/
`timescale 1ns/1ps
module sess_vid_model import sess_pkg::*; #(
  parameter int SETTLE = 6
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [VID_W-1:0] want,
  output logic [VID_W-1:0]      voltage_id_code,
  output logic                  code_valid
);
  int cnt;
  // Valid only once the new code has settled on the pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      voltage_id_code <= 8'h00;
      code_valid      <= 1'b0;
      cnt             <= SETTLE;
    end else if (want !== voltage_id_code) begin
      voltage_id_code <= want;
      code_valid      <= 1'b0;
      cnt             <= SETTLE;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      code_valid <= 1'b1;
    end
  end
endmodule

// >>> bench/tb_sess_seq.sv
/*
  Self-checking bench for the sequencer, with a dac-step queue model.
  Assumes shortened delays: init 20, hold 10, good 10 clocks.
*/
`timescale 1ns/1ps
module tb_sess_seq import sess_pkg::*;;
  localparam int INIT = 20;
  localparam int HLD  = 10;
  localparam int GD   = 10;
  logic             clk;
  logic             nrst;
  logic [5:0]       cond;
  logic             win;
  sess_mode_t       mode;
  logic             gnd;
  logic [15:0]      period;
  logic [VID_W-1:0] want;
  logic [VID_W-1:0] vid;
  logic             vvalid;
  logic [DAC_W-1:0] dac_code;
  logic             pwm_out_en;
  logic             power_good_out;
  logic             soft_start_busy;
  int               n_errors;
  int               total_checks;

  sess_seq #(.INIT_CYC(INIT), .HLD_CYC(HLD), .GD_CYC(GD), .PHASES(3)) i_sess_seq (
    .clk(clk), .nrst(nrst), .bias_por_ok(cond[0]), .enable_above(cond[1]),
    .ext_driver_enable_in(cond[2]), .first_driver_supply(cond[3]),
    .second_driver_supply(cond[4]), .third_driver_supply(cond[5]),
    .output_in_window(win), .mode(mode), .ramp_pin_grounded(gnd),
    .ramp_period_cyc(period), .voltage_id_code(vid), .code_valid(vvalid),
    .dac_code(dac_code), .pwm_out_en(pwm_out_en),
    .power_good_out(power_good_out), .soft_start_busy(soft_start_busy));
  sess_vid_model i_sess_vid_model (.clk(clk), .nrst(nrst), .want(want),
    .voltage_id_code(vid), .code_valid(vvalid));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic blocked(input logic [5:0] c);
    @(posedge clk) cond <= c;
    repeat (10) @(negedge clk);
    chk(pwm_out_en, 0);
    chk(soft_start_busy, 0);
  endtask

  // Loses one condition; outputs must drop within the sync latency
  task automatic drop(input int b);
    int n;
    n = 0;
    @(posedge clk) cond[b] <= 1'b0;
    while (pwm_out_en !== 1'b0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(n <= 4, 1);
    // Dac clears one clock after the state falls to shutdown
    @(negedge clk);
    chk(power_good_out, 0);
    chk(dac_code, 0);
  endtask

  task automatic run(input sess_mode_t m, input int tgt, input bit g,
                     input int abort_at);
    int q[$];
    int prev, gap, n, p;
    p = g ? STEP_DEF_CYC : 3 + ($urandom % 4);
    for (int v = 1; v <= 176; v++) q.push_back(v);
    if (tgt > 176) for (int v = 177; v <= tgt; v++) q.push_back(v);
    else for (int v = 175; v >= tgt; v--) q.push_back(v);
    @(posedge clk) begin
      cond <= 6'h00; mode <= m; gnd <= g; want <= tgt[7:0];
      // Non-default period proves the grounded pin wins
      period <= g ? 16'h0003 : p[15:0]; win <= 1'b1;
    end
    repeat (12) @(posedge clk);
    cond <= 6'h3f;
    n = 0;
    while (pwm_out_en !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(n <= 5, 1);
    chk(soft_start_busy, 1);
    prev = 0; gap = 0;
    for (n = 0; n < 60000 && q.size() > 0; n++) begin
      @(negedge clk);
      gap++;
      chk(power_good_out, 0);
      if (dac_code !== prev[7:0]) begin
        chk(dac_code, q.pop_front());
        if (prev == 0) chk(gap >= INIT - 1, 1);
        else if (prev == 176) chk(gap >= HLD + VALID_CYC - 1, 1);
        else chk(gap, p);
        prev = dac_code; gap = 0;
      end
      if (n == abort_at) break;
    end
    if (n == abort_at) begin
      drop($urandom % 6);
    end else begin
      chk(q.size(), 0);
      n = 0;
      while (power_good_out !== 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk(n >= GD && n <= GD + 4, 1);
      chk(soft_start_busy, 0);
      @(posedge clk) win <= 1'b0;
      repeat (4) @(negedge clk);
      chk(power_good_out, 0);
      drop($urandom % 6);
    end
  endtask

  initial begin
    #(90000 * 25);
    n_errors++;
    complete_run();
  end

  initial begin
    clk = 0; nrst = 0; cond = 6'h00; win = 0; mode = SESS_MODE_A1;
    gnd = 0; period = 16'h0004; want = 8'h40;
    n_errors = 0; total_checks = 0;
    void'($urandom(51));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(pwm_out_en, 0);
    chk(dac_code, 0);
    for (int b = 0; b < 6; b++) blocked(6'h3f ^ (6'h01 << b));
    @(posedge clk) begin mode <= SESS_MODE_B5; want <= 8'h5f; end
    blocked(6'h3f);
    run(SESS_MODE_A1, 200, 0, -1);
    run(SESS_MODE_A2, 120, 0, -1);
    run(SESS_MODE_B6, 190, 0, 60 + $urandom % 200);
    run(SESS_MODE_B6, 150 + $urandom % 20, 0, -1);
    run(SESS_MODE_B5, 181, 1, -1);
    complete_run();
  end
endmodule
